// *** fcs_array_model.sv ***
// Purpose: stand-in for the flash array and its program/erase engine
// Assumes: one operation at a time; lat cycles pass from start to the answer
// Notes: fail_mode turns the answer into a failure so the lock can be exercised
module fcs_array_model #(
  parameter logic [31:0] PATTERN = 32'h3c3c_0f0f
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [31:0] array_rd_addr,
  output logic [31:0] array_rd_data,
  input wire fcs_pkg::fcs_op_s op_req,
  input wire logic [7:0] lat,
  input wire logic fail_mode,
  output logic op_done,
  output logic op_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff = 8'h0;
  // address-derived contents so a stale or wrong address shows up at once
  assign array_rd_data = array_rd_addr ^ PATTERN;
  always_ff @(posedge clock) begin
    op_done <= 1'b0;
    op_fail <= 1'b0;
    if (sys_rst) begin
      cnt_ff <= 8'h0;
    end else if (op_req.start) begin
      cnt_ff <= lat;
    end else if (cnt_ff != 8'h0) begin
      cnt_ff <= cnt_ff - 8'h1;
      if (cnt_ff == 8'h1) begin
        op_done <= !fail_mode;
        op_fail <= fail_mode;
      end
    end
  end
endmodule : fcs_array_model

// *** fcs_pkg.sv ***
// Purpose: shared constants, types and state record of the flash command sequencer
// Assumes: 32-bit CPU store/load strobes on the system clock
// Notes: offsets are compared on address bits 15:8; bits 7:0 are never decoded
package fcs_pkg;
  // spacing the cpu must keep between command writes; the sequencer does not check it
  localparam int MIN_WR_GAP_CYC = 15;
  localparam int OFF_MSB = 15;
  localparam int OFF_LSB = 8;
  localparam int ID_SEL_MSB = 15;
  localparam int ID_SEL_LSB = 14;
  localparam int PAGE_WORDS = 4;
  localparam logic [7:0] OFF_UNLOCK_A = 8'h55;
  localparam logic [7:0] OFF_UNLOCK_B = 8'haa;
  localparam logic [7:0] DAT_UNLOCK_A = 8'haa;
  localparam logic [7:0] DAT_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_READ = 8'hf0;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_BLOCK = 8'h30;
  localparam logic [7:0] CMD_PBIT_PROG = 8'h9a;
  localparam logic [7:0] CMD_PBIT_ERASE = 8'h6a;
  localparam logic [1:0] ID_SEL_MAKER = 2'h0;
  localparam logic [1:0] ID_SEL_DEVICE = 2'h1;
  localparam logic [1:0] ID_SEL_MACRO = 2'h3;
  localparam logic [1:0] ID_SEL_RESET = 2'h0;
  localparam logic DONE_RESET = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE, ST_U1, ST_U2, ST_PG, ST_E3, ST_E4, ST_E5, ST_P6, ST_BUSY, ST_FAIL
  } fcs_state_e;

  typedef enum logic [2:0] {
    OP_PROG, OP_CHIP, OP_BLOCK, OP_PBIT_PROG, OP_PBIT_ERASE
  } fcs_op_e;

  typedef struct packed {
    logic processor_store_word;
    logic processor_load_word;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fcs_bus_s;

  typedef struct packed {
    logic start;
    fcs_op_e kind;
    logic [31:0] program_page_address;
    logic [PAGE_WORDS-1:0][31:0] program_word;
  } fcs_op_s;

  typedef struct packed {
    fcs_state_e state;
    logic id_mode;
    logic [1:0] identification_select_address;
    logic mask_rom;
    logic [1:0] word_cnt;
    logic [7:0] cmd;
    fcs_op_s op;
    logic [31:0] rdata;
    logic rvalid;
    logic done;
  } fcs_reg_s;
endpackage : fcs_pkg

// *** fcs_sequencer.sv ***
// Purpose: decodes unlock-prefixed cpu store sequences into flash operations and serves loads
// Assumes: the array engine answers each op_req.start with op_done or op_fail
// Notes: all state is one record; one comb block computes nxt_st, one clocked block stores it
module fcs_sequencer #(
  parameter logic [7:0] MAKER_CODE = 8'h3c,  // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h71, // arbitrary value
  parameter logic [7:0] MACRO_CODE = 8'h2e   // arbitrary value
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic rom_is_mask,
  input wire fcs_pkg::fcs_bus_s bus_req,
  output logic [31:0] load_data,
  output logic load_valid,
  output logic [31:0] array_rd_addr,
  input wire logic [31:0] array_rd_data,
  output fcs_pkg::fcs_op_s op_req,
  input wire logic op_done,
  input wire logic op_fail,
  output logic automatic_operation_done_flag
);
  fcs_pkg::fcs_reg_s st_ff;
  fcs_pkg::fcs_reg_s nxt_st;
  logic wr;
  logic [7:0] off;
  logic [7:0] dbyte;
  logic [1:0] wr_sel;
  logic [31:0] wr_data;
  logic [31:0] id_word;

  function automatic logic hit(input logic [7:0] o, input logic [7:0] d,
                               input logic [7:0] eo, input logic [7:0] ed);
    hit = (o == eo) && (d == ed);
  endfunction : hit

  function automatic logic [31:0] id_code(input logic [1:0] sel);
    case (sel)
      fcs_pkg::ID_SEL_MAKER: id_code = {24'h000000, MAKER_CODE};
      fcs_pkg::ID_SEL_DEVICE: id_code = {24'h000000, DEVICE_CODE};
      fcs_pkg::ID_SEL_MACRO: id_code = {24'h000000, MACRO_CODE};
      default: id_code = 32'h00000000;
    endcase
  endfunction : id_code

  // a mask rom part has no sequencer, so its stores never reach the decoder
  assign wr = bus_req.processor_store_word && !st_ff.mask_rom;
  // commands decode only offset bits 15:8 and the low data byte; page words and operation addresses keep all 32 bits
  assign off = bus_req.addr[fcs_pkg::OFF_MSB:fcs_pkg::OFF_LSB];
  assign dbyte = bus_req.wdata[7:0];
  assign wr_sel = bus_req.addr[fcs_pkg::ID_SEL_MSB:fcs_pkg::ID_SEL_LSB];
  assign wr_data = bus_req.wdata;
  assign id_word = id_code(st_ff.identification_select_address);
  assign array_rd_addr = bus_req.addr;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.op.start = 1'b0;
    nxt_st.rvalid = bus_req.processor_load_word;
    if (bus_req.processor_load_word) begin
      nxt_st.rdata = (st_ff.id_mode && !st_ff.mask_rom) ? id_word : array_rd_data;
    end
    // each store is decoded in the cycle it arrives; closely spaced stores are decoded just the same
    case (st_ff.state)
      fcs_pkg::ST_IDLE: begin
        if (wr) begin
          if (st_ff.id_mode) begin
            nxt_st.identification_select_address = wr_sel;
          end
          if (dbyte == fcs_pkg::CMD_READ) begin
            nxt_st.id_mode = 1'b0;
          end else if (hit(off, dbyte, fcs_pkg::OFF_UNLOCK_A, fcs_pkg::DAT_UNLOCK_A)) begin
            nxt_st.state = fcs_pkg::ST_U1;
          end
        end
      end
      fcs_pkg::ST_U1: begin
        if (wr) begin
          nxt_st.state = hit(off, dbyte, fcs_pkg::OFF_UNLOCK_B, fcs_pkg::DAT_UNLOCK_B) ?
                         fcs_pkg::ST_U2 : fcs_pkg::ST_IDLE;
        end
      end
      fcs_pkg::ST_U2: begin
        if (wr) begin
          nxt_st.state = fcs_pkg::ST_IDLE;
          nxt_st.cmd = dbyte;
          if (off == fcs_pkg::OFF_UNLOCK_A) begin
            case (dbyte)
              fcs_pkg::CMD_READ: nxt_st.id_mode = 1'b0;
              fcs_pkg::CMD_ID: begin
                nxt_st.id_mode = 1'b1;
                nxt_st.identification_select_address = fcs_pkg::ID_SEL_RESET;
              end
              fcs_pkg::CMD_PROG: begin
                nxt_st.state = fcs_pkg::ST_PG;
                nxt_st.word_cnt = 2'h0;
              end
              fcs_pkg::CMD_ERASE, fcs_pkg::CMD_PBIT_PROG, fcs_pkg::CMD_PBIT_ERASE: begin
                nxt_st.state = fcs_pkg::ST_E3;
              end
              default: begin
              end
            endcase
          end
        end
      end
      fcs_pkg::ST_PG: begin
        if (wr) begin
          // words fill the page in the order they arrive; the first store names the page
          nxt_st.op.program_word[st_ff.word_cnt] = wr_data;
          if (st_ff.word_cnt == 2'h0) begin
            nxt_st.op.program_page_address = bus_req.addr;
          end
          nxt_st.word_cnt = st_ff.word_cnt + 2'h1;
          if (st_ff.word_cnt == 2'h3) begin
            nxt_st.op.start = 1'b1;
            nxt_st.op.kind = fcs_pkg::OP_PROG;
            nxt_st.state = fcs_pkg::ST_BUSY;
          end
        end
      end
      fcs_pkg::ST_E3: begin
        if (wr) begin
          nxt_st.state = hit(off, dbyte, fcs_pkg::OFF_UNLOCK_A, fcs_pkg::DAT_UNLOCK_A) ?
                         fcs_pkg::ST_E4 : fcs_pkg::ST_IDLE;
        end
      end
      fcs_pkg::ST_E4: begin
        if (wr) begin
          nxt_st.state = hit(off, dbyte, fcs_pkg::OFF_UNLOCK_B, fcs_pkg::DAT_UNLOCK_B) ?
                         fcs_pkg::ST_E5 : fcs_pkg::ST_IDLE;
        end
      end
      fcs_pkg::ST_E5: begin
        if (wr) begin
          nxt_st.state = fcs_pkg::ST_IDLE;
          nxt_st.op.program_page_address = bus_req.addr;
          if (st_ff.cmd == fcs_pkg::CMD_ERASE) begin
            if (hit(off, dbyte, fcs_pkg::OFF_UNLOCK_A, fcs_pkg::CMD_CHIP)) begin
              nxt_st.op.start = 1'b1;
              nxt_st.op.kind = fcs_pkg::OP_CHIP;
              nxt_st.state = fcs_pkg::ST_BUSY;
            end else if (dbyte == fcs_pkg::CMD_BLOCK) begin
              nxt_st.op.start = 1'b1;
              nxt_st.op.kind = fcs_pkg::OP_BLOCK;
              nxt_st.state = fcs_pkg::ST_BUSY;
            end
          end else if (hit(off, dbyte, fcs_pkg::OFF_UNLOCK_A, st_ff.cmd)) begin
            nxt_st.state = fcs_pkg::ST_P6;
          end
        end
      end
      fcs_pkg::ST_P6: begin
        if (wr) begin
          nxt_st.state = fcs_pkg::ST_IDLE;
          if (dbyte == st_ff.cmd) begin
            nxt_st.op.start = 1'b1;
            nxt_st.op.kind = (st_ff.cmd == fcs_pkg::CMD_PBIT_PROG) ? fcs_pkg::OP_PBIT_PROG :
                             fcs_pkg::OP_PBIT_ERASE;
            nxt_st.op.program_page_address = bus_req.addr;
            nxt_st.state = fcs_pkg::ST_BUSY;
          end
        end
      end
      fcs_pkg::ST_BUSY: begin
        // stores are dropped here; only the engine's answer moves the state
        if (op_fail) begin
          nxt_st.state = fcs_pkg::ST_FAIL;
        end else if (op_done) begin
          nxt_st.state = fcs_pkg::ST_IDLE;
        end
      end
      fcs_pkg::ST_FAIL: begin
        // a failed operation locks the sequencer until system reset
        nxt_st.state = fcs_pkg::ST_FAIL;
      end
      default: nxt_st.state = fcs_pkg::ST_IDLE;
    endcase
    nxt_st.done = (nxt_st.state != fcs_pkg::ST_BUSY) && (nxt_st.state != fcs_pkg::ST_FAIL);
    if (sys_rst) begin
      nxt_st = '0;
      nxt_st.state = fcs_pkg::ST_IDLE;
      nxt_st.done = fcs_pkg::DONE_RESET;
      // strap is caught while reset is held, the bus is idle then
      nxt_st.mask_rom = rom_is_mask;
    end
  end

  always_ff @(posedge clock) begin
    st_ff <= nxt_st;
  end

  assign load_data = st_ff.rdata;
  assign load_valid = st_ff.rvalid;
  assign op_req = st_ff.op;
  assign automatic_operation_done_flag = st_ff.done;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_id_load;
    bus_req.processor_load_word && st_ff.id_mode && !st_ff.mask_rom;
  endsequence
  sequence s_page_last;
    wr && st_ff.state == fcs_pkg::ST_PG && st_ff.word_cnt == 2'h3;
  endsequence

  id_load_a: assert property (s_id_load |=> load_valid && load_data == $past(id_word))
    else $error("id load returned wrong value");
  id_select_a: assert property (wr && st_ff.id_mode && st_ff.state == fcs_pkg::ST_IDLE
    |=> st_ff.identification_select_address == $past(wr_sel))
    else $error("id select not taken from address");
  id_stay_a: assert property (st_ff.id_mode && !(wr && dbyte == fcs_pkg::CMD_READ) |=> st_ff.id_mode)
    else $error("id mode left without read command");
  id_exit_a: assert property (st_ff.id_mode && wr && dbyte == fcs_pkg::CMD_READ &&
    (st_ff.state == fcs_pkg::ST_IDLE || (st_ff.state == fcs_pkg::ST_U2 && off == fcs_pkg::OFF_UNLOCK_A))
    |=> !st_ff.id_mode)
    else $error("read command did not leave id mode");
  mask_ignore_a: assert property (st_ff.mask_rom |-> st_ff.state == fcs_pkg::ST_IDLE && !op_req.start
    && !st_ff.id_mode)
    else $error("mask rom part reacted to a store");
  page_start_a: assert property (s_page_last |=> op_req.start && op_req.kind == fcs_pkg::OP_PROG
    && op_req.program_word[3] == $past(wr_data))
    else $error("page program not started after fourth word");
  chip_start_a: assert property (wr && st_ff.state == fcs_pkg::ST_E5 && st_ff.cmd == fcs_pkg::CMD_ERASE
    && hit(off, dbyte, fcs_pkg::OFF_UNLOCK_A, fcs_pkg::CMD_CHIP)
    |=> op_req.start && op_req.kind == fcs_pkg::OP_CHIP)
    else $error("chip erase not started");
  busy_refuse_a: assert property (st_ff.state == fcs_pkg::ST_BUSY && !op_done && !op_fail
    |=> !op_req.start && st_ff.state == fcs_pkg::ST_BUSY)
    else $error("command accepted while busy");
  done_flag_a: assert property ((st_ff.state == fcs_pkg::ST_BUSY || st_ff.state == fcs_pkg::ST_FAIL)
    |-> !automatic_operation_done_flag)
    else $error("done flag high while busy or failed");
  // the flag must come back once the engine reports a clean end, or software would poll forever
  done_release_a: assert property (st_ff.state == fcs_pkg::ST_BUSY && op_done && !op_fail
    |=> automatic_operation_done_flag && st_ff.state == fcs_pkg::ST_IDLE)
    else $error("done flag not raised after operation end");
  fail_hold_a: assert property (st_ff.state == fcs_pkg::ST_FAIL |=> !automatic_operation_done_flag [*3])
    else $error("failed state released without reset");
  unlock_abort_a: assert property (wr && st_ff.state == fcs_pkg::ST_U1 &&
    !hit(off, dbyte, fcs_pkg::OFF_UNLOCK_B, fcs_pkg::DAT_UNLOCK_B)
    |=> st_ff.state == fcs_pkg::ST_IDLE && !op_req.start)
    else $error("broken unlock not abandoned");
  array_read_a: assert property (bus_req.processor_load_word && !st_ff.id_mode
    |=> load_valid && load_data == $past(array_rd_data))
    else $error("array load returned wrong data");
endmodule : fcs_sequencer

// *** flash_command_sequencer_bench.sv ***
// Purpose: self-checking bench for the flash command sequencer
// Assumes: id codes left at the sequencer defaults 3c, 71, 2e
// Notes: stores are spaced 17 clocks apart, as software must do
module flash_command_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] B = 32'hbfc0_0000;
  localparam logic [31:0] PAT = 32'h3c3c_0f0f;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic rom_is_mask = 1'b0;
  logic fail_mode = 1'b0;
  logic [7:0] lat = 8'h3;
  fcs_pkg::fcs_bus_s bus_req = '0;
  logic [31:0] load_data, array_rd_addr, array_rd_data;
  logic load_valid, op_done, op_fail, flag;
  fcs_pkg::fcs_op_s op_req, last_op;
  int err_total = 0, cmp_count = 0, cyc = 0, starts = 0;
  always #20 clock = ~clock;
  fcs_sequencer uut (.clock(clock), .sys_rst(sys_rst), .rom_is_mask(rom_is_mask), .bus_req(bus_req),
    .load_data(load_data), .load_valid(load_valid), .array_rd_addr(array_rd_addr),
    .array_rd_data(array_rd_data), .op_req(op_req), .op_done(op_done), .op_fail(op_fail),
    .automatic_operation_done_flag(flag));
  fcs_array_model #(.PATTERN(PAT)) arr (.clock(clock), .sys_rst(sys_rst), .array_rd_addr(array_rd_addr),
    .array_rd_data(array_rd_data), .op_req(op_req), .lat(lat), .fail_mode(fail_mode),
    .op_done(op_done), .op_fail(op_fail));
  always @(posedge clock) begin
    cyc++;
    if (op_req.start === 1'b1) begin
      starts++;
      last_op = op_req;
    end
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic st(input logic [31:0] a, input logic [31:0] d);
    @(negedge clock);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(negedge clock);
    bus_req.processor_store_word <= 1'b0;
    repeat (fcs_pkg::MIN_WR_GAP_CYC) @(negedge clock);
  endtask : st
  task automatic unl();
    st(B | 32'h5500, 32'haa);
    st(B | 32'haa00, 32'h55);
  endtask : unl
  task automatic cmd(input logic [7:0] c);
    unl();
    st(B | 32'h5500, {24'h0, c});
  endtask : cmd
  task automatic ld(input string what, input logic [31:0] a, input logic [31:0] exp);
    @(negedge clock);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(negedge clock);
    bus_req.processor_load_word <= 1'b0;
    chk("load valid", {31'h0, load_valid}, 32'h1);
    chk(what, load_data, exp);
  endtask : ld
  task automatic wflag(input logic exp);
    int n = 0;
    while (flag !== exp && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk("done flag", {31'h0, flag}, {31'h0, exp});
  endtask : wflag
  task automatic do_reset(input logic m);
    @(negedge clock);
    sys_rst <= 1'b1;
    rom_is_mask <= m;
    repeat (2) @(negedge clock);
    sys_rst <= 1'b0;
  endtask : do_reset
  task automatic t_id();
    logic [31:0] code [4] = '{32'h3c, 32'h71, 32'h0, 32'h2e};
    chk("reset flag", {31'h0, flag}, 32'h1);
    ld("array", B | 32'h0040, (B | 32'h0040) ^ PAT);
    cmd(8'h90);
    for (int i = 0; i < 4; i++) begin
      st(B | {16'h0, i[1:0], 14'h0}, 32'h0);
      ld("id value", B | 32'h0104, code[i]);
    end
    st(B, 32'hf0);
    ld("after read", B | 32'h0104, (B | 32'h0104) ^ PAT);
    cmd(8'h90);
    st(B | 32'h4000, 32'h0);
    cmd(8'hf0);
    ld("after read reset", B | 32'h0200, (B | 32'h0200) ^ PAT);
  endtask : t_id
  task automatic t_prog();
    int s = starts;
    lat <= 8'h28;
    cmd(8'ha0);
    for (int i = 0; i < 4; i++) st(B + 32'h1230 + 32'(4 * i), 32'ha5a5_0000 | i);
    chk("start count", starts, s + 1);
    chk("kind", 32'(last_op.kind), 32'(fcs_pkg::OP_PROG));
    chk("page", last_op.program_page_address, B | 32'h1230);
    for (int i = 0; i < 4; i++) chk("word", last_op.program_word[i], 32'ha5a5_0000 | i);
    chk("busy flag", {31'h0, flag}, 32'h0);
    wflag(1'b1);
    // long engine time so a whole program sequence lands while busy
    lat <= 8'hc8;
    cmd(8'h80);
    unl();
    st(B | 32'h5500, 32'h10);
    cmd(8'ha0);
    for (int i = 0; i < 4; i++) st(B + 32'(4 * i), 32'h0);
    wflag(1'b1);
    chk("refused", starts, s + 2);
    chk("chip kind", 32'(last_op.kind), 32'(fcs_pkg::OP_CHIP));
  endtask : t_prog
  task automatic t_erase();
    logic [7:0] c [3] = '{8'h80, 8'h9a, 8'h6a};
    fcs_pkg::fcs_op_e k [3] = '{fcs_pkg::OP_BLOCK, fcs_pkg::OP_PBIT_PROG, fcs_pkg::OP_PBIT_ERASE};
    lat <= 8'h3;
    for (int i = 0; i < 3; i++) begin
      cmd(c[i]);
      unl();
      if (i == 0) st(B + 32'h0004_0000, 32'h30);
      else begin
        st(B | 32'h5500, {24'h0, c[i]});
        st(B | 32'h8000, {24'h0, c[i]});
      end
      wflag(1'b1);
      chk("kind", 32'(last_op.kind), 32'(k[i]));
      chk("addr", last_op.program_page_address, i == 0 ? B + 32'h0004_0000 : B | 32'h8000);
    end
  endtask : t_erase
  task automatic t_odd();
    int s = starts;
    st(B | 32'h5500, 32'haa);
    st(B | 32'haa00, 32'h12);
    st(B | 32'h5500, 32'h90);
    st(B | 32'h4000, 32'h0);
    ld("broken", B | 32'h0300, (B | 32'h0300) ^ PAT);
    st(B | 32'h5500, 32'haa);
    st(B | 32'h5500, 32'ha0);
    for (int i = 0; i < 4; i++) st(B + 32'(4 * i), 32'h0);
    chk("no start", starts, s);
    fail_mode <= 1'b1;
    cmd(8'h80);
    unl();
    st(B | 32'h5500, 32'h10);
    repeat (10) @(negedge clock);
    chk("failed flag", {31'h0, flag}, 32'h0);
    cmd(8'hf0);
    chk("failed flag", {31'h0, flag}, 32'h0);
    fail_mode <= 1'b0;
    do_reset(1'b1);
    chk("flag after reset", {31'h0, flag}, 32'h1);
    s = starts;
    cmd(8'h90);
    st(B | 32'h4000, 32'h0);
    ld("mask rom", B | 32'h0104, (B | 32'h0104) ^ PAT);
    cmd(8'h80);
    unl();
    st(B | 32'h5500, 32'h10);
    chk("mask no start", starts, s);
    do_reset(1'b0);
  endtask : t_odd
  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (2) @(negedge clock);
    sys_rst <= 1'b0;
    t_id();
    t_prog();
    t_erase();
    t_odd();
    wrap_up();
  end
endmodule : flash_command_sequencer_bench
